// *** rtl/ebs_pkg.sv ***
package ebs_pkg;

  // clock and timebase
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TICK_PERIOD_NS = 10_000_000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W     = 20;

  // field widths
  localparam int DLY_W  = 10;
  localparam int FREQ_W = 16;
  localparam int CUR_W  = 5;
  localparam int IRQ_W  = 4;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_REL_DLY   = 8'h04;
  localparam logic [7:0] OFS_ACC_DLY   = 8'h08;
  localparam logic [7:0] OFS_STOP_DLY  = 8'h0c;
  localparam logic [7:0] OFS_CONF_WAIT = 8'h10;
  localparam logic [7:0] OFS_REL_FREQ  = 8'h14;
  localparam logic [7:0] OFS_REL_CUR   = 8'h18;
  localparam logic [7:0] OFS_STATUS    = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STS   = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLR   = 8'h24;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h28;

  // control bits
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_CONF_BIT = 1;
  localparam int CTRL_FCLR_BIT = 2;

  // status bits
  localparam int STS_REL_BIT  = 4;
  localparam int STS_FLT_BIT  = 5;
  localparam int STS_CONF_BIT = 6;

  // interrupt bits
  localparam int IRQ_FAULT   = 0;
  localparam int IRQ_REL_ON  = 1;
  localparam int IRQ_REL_OFF = 2;
  localparam int IRQ_STOPPED = 3;

  // reset values
  localparam logic [DLY_W-1:0]  RST_DLY      = 10'h000;
  localparam logic [FREQ_W-1:0] RST_REL_FREQ = 16'h0000;
  localparam logic [CUR_W-1:0]  RST_REL_CUR  = 5'h0a;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_ACC_REL   = 4'b0001,
    ST_REL_WAIT  = 4'b0010,
    ST_CONF_ON   = 4'b0011,
    ST_ACC_WAIT  = 4'b0100,
    ST_RUN       = 4'b0101,
    ST_DEC_REL   = 4'b0110,
    ST_CONF_OFF  = 4'b0111,
    ST_STOP_WAIT = 4'b1000,
    ST_DEC_ZERO  = 4'b1001,
    ST_FAULT     = 4'b1010
  } ebs_state_e;

  typedef struct packed {
    logic              enable;
    logic              conf_used;
    logic [DLY_W-1:0]  rel_dly;
    logic [DLY_W-1:0]  acc_dly;
    logic [DLY_W-1:0]  stop_dly;
    logic [DLY_W-1:0]  conf_wait;
    logic [FREQ_W-1:0] rel_freq;
    logic [CUR_W-1:0]  rel_cur;
  } ebs_cfg_s;

endpackage

// *** rtl/ebs_tick.sv ***
`timescale 1ns/100ps
module ebs_tick
  import ebs_pkg::*;
#(
  parameter int TICKS = TICK_CYCLES
) (
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  input  wire logic restart_i,
  output logic      tick_o
);

  logic [TICK_CNT_W-1:0] cnt_q;
  logic                  wrap;

  assign wrap = (cnt_q == TICK_CNT_W'(TICKS - 1));

  // 0.01 s timebase, realigned at each sequence step
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
    end else if (restart_i || wrap) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign tick_o = wrap && !restart_i;

endmodule

// *** rtl/ebs_seq.sv ***
// Notes on behaviour
// [R1] sequence active only when enable set
// [R2] run starts ramp to release frequency
// [R3] wait release delay before brake release
// [R4] low current at delay end trips
// [R5] wait for confirmation, timeout trips
// [R6] no confirm input skips start wait
// [R7] acceleration delay then ramp to command
// [R8] run off ramps down, release drops
// [R9] confirmation must drop within wait time
// [R10] no confirm input skips stop wait
// [R11] stop delay then ramp to 0 Hz
// [R12] confirm drop while released during decel trips
// [R13] release frequency set above start frequency
// [R14] confirm input assigned by configuring party
// [R15] all delays counted in 0.01 s ticks
`timescale 1ns/100ps
module ebs_seq
  import ebs_pkg::*;
#(
  parameter int TICKS = TICK_CYCLES
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rstn_i,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              run_cmd_i,
  input  wire logic [FREQ_W-1:0] cmd_freq_i,
  input  wire logic [FREQ_W-1:0] out_freq_i,
  input  wire logic [CUR_W-1:0]  out_current_i,
  input  wire logic              brake_confirm_in_i,
  output logic      [FREQ_W-1:0] freq_target_o,
  output logic                   drive_run_o,
  output logic                   brake_release_out_o,
  output logic                   brake_fault_out_o,
  output logic                   irq_o
);

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFS_CTRL) || (a == OFS_REL_DLY) ||
                (a == OFS_ACC_DLY) || (a == OFS_STOP_DLY) ||
                (a == OFS_CONF_WAIT) || (a == OFS_REL_FREQ) ||
                (a == OFS_REL_CUR) || (a == OFS_STATUS) ||
                (a == OFS_IRQ_STS) || (a == OFS_IRQ_CLR) ||
                (a == OFS_IRQ_EN);
  endfunction

  function automatic logic holds_rel(input ebs_state_e s);
    holds_rel = (s == ST_ACC_REL) || (s == ST_REL_WAIT) ||
                (s == ST_CONF_ON) || (s == ST_ACC_WAIT) ||
                (s == ST_DEC_REL) || (s == ST_CONF_OFF) ||
                (s == ST_STOP_WAIT);
  endfunction

  function automatic logic rel_on(input ebs_state_e s);
    rel_on = (s == ST_CONF_ON) || (s == ST_ACC_WAIT) ||
             (s == ST_RUN) || (s == ST_DEC_REL);
  endfunction

  ebs_cfg_s          cfg_q;
  ebs_state_e        state_q;
  ebs_state_e        state_d;
  logic [DLY_W-1:0]  elapsed_q;
  logic [IRQ_W-1:0]  irq_sts_q;
  logic [IRQ_W-1:0]  irq_en_q;
  logic [IRQ_W-1:0]  irq_ev;
  logic [FREQ_W-1:0] freq_target_d;
  logic              flt_clr_q;
  logic              tick;
  logic              step;
  logic              wr;
  logic              rel_done;
  logic              acc_done;
  logic              stop_done;
  logic              conf_done;

  // apb access
  assign wr      = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !is_mapped(paddr);

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_q <= '{enable: 1'b0, conf_used: 1'b0, rel_dly: RST_DLY,
                 acc_dly: RST_DLY, stop_dly: RST_DLY,
                 conf_wait: RST_DLY, rel_freq: RST_REL_FREQ,
                 rel_cur: RST_REL_CUR};
      irq_en_q <= '0;
    end else if (wr) begin
      case (paddr)
        OFS_CTRL: begin
          cfg_q.enable    <= pwdata[CTRL_EN_BIT];
          cfg_q.conf_used <= pwdata[CTRL_CONF_BIT];
        end
        OFS_REL_DLY:   cfg_q.rel_dly   <= pwdata[DLY_W-1:0];
        OFS_ACC_DLY:   cfg_q.acc_dly   <= pwdata[DLY_W-1:0];
        OFS_STOP_DLY:  cfg_q.stop_dly  <= pwdata[DLY_W-1:0];
        OFS_CONF_WAIT: cfg_q.conf_wait <= pwdata[DLY_W-1:0];
        OFS_REL_FREQ:  cfg_q.rel_freq  <= pwdata[FREQ_W-1:0];
        OFS_REL_CUR:   cfg_q.rel_cur   <= pwdata[CUR_W-1:0];
        OFS_IRQ_EN:    irq_en_q        <= pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // fault reset strobe
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flt_clr_q <= 1'b0;
    end else begin
      flt_clr_q <= wr && (paddr == OFS_CTRL) && pwdata[CTRL_FCLR_BIT];
    end
  end

  // read data captured in the setup phase
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      prdata <= '0;
      case (paddr)
        OFS_CTRL: begin
          prdata[CTRL_EN_BIT]   <= cfg_q.enable;
          prdata[CTRL_CONF_BIT] <= cfg_q.conf_used;
        end
        OFS_REL_DLY:   prdata[DLY_W-1:0]  <= cfg_q.rel_dly;
        OFS_ACC_DLY:   prdata[DLY_W-1:0]  <= cfg_q.acc_dly;
        OFS_STOP_DLY:  prdata[DLY_W-1:0]  <= cfg_q.stop_dly;
        OFS_CONF_WAIT: prdata[DLY_W-1:0]  <= cfg_q.conf_wait;
        OFS_REL_FREQ:  prdata[FREQ_W-1:0] <= cfg_q.rel_freq;
        OFS_REL_CUR:   prdata[CUR_W-1:0]  <= cfg_q.rel_cur;
        OFS_STATUS: begin
          prdata[3:0]          <= state_q;
          prdata[STS_REL_BIT]  <= brake_release_out_o;
          prdata[STS_FLT_BIT]  <= brake_fault_out_o;
          prdata[STS_CONF_BIT] <= brake_confirm_in_i;
        end
        OFS_IRQ_STS:   prdata[IRQ_W-1:0]  <= irq_sts_q;
        OFS_IRQ_EN:    prdata[IRQ_W-1:0]  <= irq_en_q;
        default: ;
      endcase
    end
  end

  // delay timing
  assign step = (state_d != state_q);

  ebs_tick #(
    .TICKS (TICKS)
  ) u_tick (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .restart_i (step),
    .tick_o    (tick)
  );

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      elapsed_q <= '0;
    end else if (step) begin
      elapsed_q <= '0;
    end else if (tick && !(&elapsed_q)) begin
      elapsed_q <= elapsed_q + 1'b1; // [R15]
    end
  end

  assign rel_done  = (elapsed_q >= cfg_q.rel_dly);
  assign acc_done  = (elapsed_q >= cfg_q.acc_dly);
  assign stop_done = (elapsed_q >= cfg_q.stop_dly);
  assign conf_done = (elapsed_q >= cfg_q.conf_wait);

  // sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (cfg_q.enable && run_cmd_i) begin
          state_d = ST_ACC_REL; // [R2]
        end
      ST_ACC_REL:
        if (!run_cmd_i) begin
          state_d = ST_DEC_ZERO;
        end else if (out_freq_i >= cfg_q.rel_freq) begin
          state_d = ST_REL_WAIT; // [R2]
        end
      ST_REL_WAIT:
        if (!run_cmd_i) begin
          state_d = ST_DEC_ZERO;
        end else if (rel_done) begin
          if (out_current_i < cfg_q.rel_cur) begin
            state_d = ST_FAULT; // [R4]
          end else if (cfg_q.conf_used) begin
            state_d = ST_CONF_ON; // [R3]
          end else begin
            state_d = ST_ACC_WAIT; // [R6]
          end
        end
      ST_CONF_ON:
        if (!run_cmd_i) begin
          state_d = ST_DEC_REL;
        end else if (brake_confirm_in_i) begin
          state_d = ST_ACC_WAIT; // [R5]
        end else if (conf_done) begin
          state_d = ST_FAULT; // [R5]
        end
      ST_ACC_WAIT:
        if (!run_cmd_i) begin
          state_d = ST_DEC_REL;
        end else if (acc_done) begin
          state_d = ST_RUN; // [R7]
        end
      ST_RUN:
        if (!run_cmd_i) begin
          state_d = ST_DEC_REL; // [R8]
        end
      ST_DEC_REL:
        if (cfg_q.conf_used && !brake_confirm_in_i) begin
          state_d = ST_FAULT; // [R12]
        end else if (out_freq_i <= cfg_q.rel_freq) begin
          // [R8]
          state_d = cfg_q.conf_used ? ST_CONF_OFF : ST_STOP_WAIT; // [R10]
        end
      ST_CONF_OFF:
        if (!brake_confirm_in_i) begin
          state_d = ST_STOP_WAIT; // [R9]
        end else if (conf_done) begin
          state_d = ST_FAULT; // [R9]
        end
      ST_STOP_WAIT:
        if (stop_done) begin
          state_d = ST_DEC_ZERO; // [R11]
        end
      ST_DEC_ZERO:
        if (out_freq_i == '0) begin
          state_d = ST_IDLE;
        end
      ST_FAULT:
        if (flt_clr_q && !run_cmd_i) begin
          state_d = ST_IDLE;
        end
      default: state_d = ST_IDLE;
    endcase
    if (!cfg_q.enable && state_d != ST_FAULT) begin
      state_d = ST_IDLE; // [R1]
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // drive outputs
  always_comb begin
    if (!cfg_q.enable) begin
      freq_target_d = run_cmd_i ? cmd_freq_i : '0; // [R1]
    end else if (state_d == ST_RUN) begin
      freq_target_d = cmd_freq_i; // [R7]
    end else if (holds_rel(state_d)) begin
      freq_target_d = cfg_q.rel_freq; // [R2]
    end else begin
      freq_target_d = '0; // [R11]
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      freq_target_o       <= '0;
      drive_run_o         <= 1'b0;
      brake_release_out_o <= 1'b0;
      brake_fault_out_o   <= 1'b0;
    end else begin
      freq_target_o       <= freq_target_d;
      drive_run_o         <= cfg_q.enable ?
                             (state_d != ST_IDLE && state_d != ST_FAULT) :
                             run_cmd_i;
      brake_release_out_o <= cfg_q.enable && rel_on(state_d); // [R1]
      brake_fault_out_o   <= (state_d == ST_FAULT); // [R4]
    end
  end

  // interrupts
  assign irq_ev[IRQ_FAULT]   = (state_d == ST_FAULT) && (state_q != ST_FAULT);
  assign irq_ev[IRQ_REL_ON]  = rel_on(state_d) && !rel_on(state_q);
  assign irq_ev[IRQ_REL_OFF] = !rel_on(state_d) && rel_on(state_q);
  assign irq_ev[IRQ_STOPPED] = (state_q == ST_DEC_ZERO) &&
                               (state_d == ST_IDLE);

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_sts_q <= '0;
    end else if (wr && paddr == OFS_IRQ_CLR) begin
      irq_sts_q <= (irq_sts_q & ~pwdata[IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_sts_q <= irq_sts_q | irq_ev;
    end
  end

  assign irq_o = |(irq_sts_q & irq_en_q);

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_rel_wait_end;
    state_q == ST_REL_WAIT && run_cmd_i && cfg_q.enable && rel_done;
  endsequence

  sequence s_faulted;
    state_q == ST_FAULT && brake_fault_out_o && !brake_release_out_o;
  endsequence

  chk_disabled_no_rel: assert property ( // [R1]
    !cfg_q.enable [*2] |-> !brake_release_out_o)
    else $error("release active while sequence disabled");

  chk_ramp_to_rel: assert property ( // [R2]
    state_q == ST_ACC_REL && cfg_q.enable ##1 state_q == ST_ACC_REL
    |-> freq_target_o == cfg_q.rel_freq)
    else $error("start ramp target is not release frequency");

  chk_rel_after_delay: assert property ( // [R3]
    $rose(brake_release_out_o) |-> $past(state_q) == ST_REL_WAIT &&
    $past(elapsed_q) >= $past(cfg_q.rel_dly))
    else $error("release asserted before release delay");

  chk_low_cur_trip: assert property ( // [R4]
    s_rel_wait_end ##0 out_current_i < cfg_q.rel_cur |=> s_faulted)
    else $error("low current did not trip");

  chk_conf_timeout: assert property ( // [R5]
    state_q == ST_CONF_ON && run_cmd_i && cfg_q.enable &&
    !brake_confirm_in_i && conf_done |=> s_faulted)
    else $error("missing confirmation did not trip");

  chk_no_conf_skip: assert property ( // [R6]
    $rose(brake_release_out_o) && !$past(cfg_q.conf_used)
    |-> state_q == ST_ACC_WAIT)
    else $error("confirmation wait not skipped");

  chk_run_after_wait: assert property ( // [R7]
    state_q == ST_RUN && $past(state_q) != ST_RUN
    |-> $past(state_q) == ST_ACC_WAIT && $past(acc_done))
    else $error("run entered without acceleration delay");

  chk_decel_conf_drop: assert property ( // [R12]
    state_q == ST_DEC_REL && cfg_q.enable && cfg_q.conf_used &&
    !brake_confirm_in_i |=> s_faulted)
    else $error("confirmation drop in decel did not trip");

  chk_stop_zero: assert property ( // [R11]
    state_q == ST_DEC_ZERO && cfg_q.enable |=> freq_target_o == '0)
    else $error("stop ramp target is not zero");

endmodule

// *** tb/ebs_brake_model.sv ***
`timescale 1ns/100ps
module ebs_brake_model #(
  parameter int DLY = 3
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       release_i,
  input  wire logic [1:0] mode_i,
  output logic            confirm_o
);
  logic [DLY-1:0] lag_q;

  // contact follows the shoe a few cycles late
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      lag_q <= '0;
    else
      lag_q <= {lag_q[DLY-2:0], release_i};
  end

  // mode 1 stuck open, mode 3 stuck closed, else real contact
  assign confirm_o = (mode_i == 2'h1) ? 1'b0 :
                     (mode_i == 2'h3) ? 1'b1 : lag_q[DLY-1];
endmodule

// *** tb/ebs_seq_test.sv ***
`timescale 1ns/100ps
module ebs_seq_test;
  import ebs_pkg::*;
  localparam int          T     = 4;
  localparam logic [15:0] REL_F = 16'h01f4;
  localparam logic [15:0] CMD_F = 16'h0bb8;
  logic        sys_clk_i, rstn_i, psel, penable, pwrite, pready, pslverr;
  logic        run_cmd, drive_run, rel, flt, irq, conf, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] tgt, out_freq, goal;
  logic [4:0]  cur;
  logic [1:0]  mode;
  int          mismatches, num_checks, n;

  ebs_seq #(.TICKS(T)) ebs_seq_i (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .run_cmd_i(run_cmd), .cmd_freq_i(CMD_F), .out_freq_i(out_freq),
    .out_current_i(cur), .brake_confirm_in_i(conf), .freq_target_o(tgt),
    .drive_run_o(drive_run), .brake_release_out_o(rel),
    .brake_fault_out_o(flt), .irq_o(irq));

  ebs_brake_model #(.DLY(3)) ebs_brake_model_i (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .release_i(rel),
    .mode_i(mode), .confirm_o(conf));

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // simple frequency ramp of the drive, 1 Hz a cycle
  assign goal = drive_run ? tgt : 16'h0;
  always @(posedge sys_clk_i) begin
    if (out_freq + 16'h64 <= goal)
      out_freq <= out_freq + 16'h64;
    else if (out_freq >= goal + 16'h64)
      out_freq <= out_freq - 16'h64;
    else
      out_freq <= goal;
  end

  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [15:0] pick(input int w);
    case (w)
      0: pick = {15'h0, rel};
      1: pick = {15'h0, flt};
      2: pick = tgt;
      3: pick = {15'h0, drive_run};
      4: pick = out_freq;
      default: pick = {15'h0, conf};
    endcase
  endfunction

  task automatic wait_sig(input int w, input logic [15:0] v, input int lim);
    n = 0;
    while (pick(w) !== v && n < lim) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk(pick(w) === v, "level not reached in time");
  endtask

  task automatic go(input logic v, input logic [1:0] m);
    @(posedge sys_clk_i);
    run_cmd <= v;
    mode <= m;
  endtask

  task automatic cfg(input logic [1:0] c);
    apb(1'b1, OFS_REL_DLY, 32'h2);
    apb(1'b1, OFS_ACC_DLY, 32'h1);
    apb(1'b1, OFS_STOP_DLY, 32'h1);
    apb(1'b1, OFS_CONF_WAIT, 32'h4);
    apb(1'b1, OFS_REL_FREQ, {16'h0, REL_F});
    apb(1'b1, OFS_CTRL, {30'h0, c});
  endtask

  task automatic clear_fault;
    @(posedge sys_clk_i);
    run_cmd <= 1'b0;
    cur <= 5'h0a;
    mode <= 2'h0;
    apb(1'b1, OFS_CTRL, 32'h4);
    wait_sig(1, 16'h0, 5);
    wait_sig(4, 16'h0, 100);
  endtask

  task automatic t_regs;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd === 32'h0 && err === 1'b0, "ctrl reset value");
    apb(1'b0, OFS_REL_CUR, 32'h0);
    chk(rd === 32'ha && err === 1'b0, "release current reset value");
    apb(1'b0, 8'h30, 32'h0);
    chk(rd === 32'h0 && err === 1'b1, "unmapped read");
    $display("test regs done");
  endtask

  task automatic t_disabled;
    go(1'b1, 2'h0);
    repeat (40) @(posedge sys_clk_i);
    #1;
    chk(rel === 1'b0 && tgt === CMD_F, "disabled sequence");
    go(1'b0, 2'h0);
    wait_sig(4, 16'h0, 100);
    $display("test disabled done");
  endtask

  task automatic t_plain;
    apb(1'b1, OFS_IRQ_EN, 32'hf);
    cfg(2'h1);
    go(1'b1, 2'h0);
    wait_sig(2, REL_F, 5);
    chk(drive_run === 1'b1, "drive not started");
    wait_sig(4, REL_F, 50);
    wait_sig(0, 16'h1, 40);
    chk(n >= 2*T && n <= 2*T+3, "release delay");
    wait_sig(2, CMD_F, 40);
    chk(n >= T && n <= T+3, "accel wait");
    wait_sig(4, CMD_F, 60);
    go(1'b0, 2'h0);
    wait_sig(2, REL_F, 5);
    wait_sig(0, 16'h0, 60);
    chk(out_freq === REL_F, "release off away from release freq");
    wait_sig(2, 16'h0, 40);
    chk(n >= T && n <= T+3, "stop wait");
    wait_sig(3, 16'h0, 80);
    apb(1'b0, OFS_IRQ_STS, 32'h0);
    chk(rd === 32'he && irq === 1'b1, "events pending");
    apb(1'b1, OFS_IRQ_EN, 32'h0);
    #1;
    chk(irq === 1'b0, "masked interrupt");
    apb(1'b1, OFS_IRQ_CLR, 32'hf);
    apb(1'b1, OFS_IRQ_EN, 32'hf);
    #1;
    chk(irq === 1'b0, "cleared interrupt");
    $display("test plain start stop done");
  endtask

  task automatic t_early_stop;
    go(1'b1, 2'h0);
    wait_sig(4, REL_F, 50);
    go(1'b0, 2'h0);
    wait_sig(2, 16'h0, 5);
    wait_sig(3, 16'h0, 40);
    chk(rel === 1'b0 && flt === 1'b0, "release on early stop");
    apb(1'b0, OFS_IRQ_STS, 32'h0);
    chk(rd === 32'h8, "early stop events");
    apb(1'b1, OFS_IRQ_CLR, 32'hf);
    $display("test early stop done");
  endtask

  task automatic t_low_current;
    cfg(2'h1);
    @(posedge sys_clk_i);
    cur <= 5'h09;
    run_cmd <= 1'b1;
    wait_sig(1, 16'h1, 60);
    chk(rel === 1'b0, "release with low current");
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[STS_FLT_BIT] === 1'b1, "fault status");
    chk(irq === 1'b1, "fault interrupt");
    clear_fault;
    $display("test low current done");
  endtask

  task automatic t_confirm;
    cfg(2'h3);
    go(1'b1, 2'h0);
    wait_sig(0, 16'h1, 60);
    wait_sig(5, 16'h1, 10);
    wait_sig(2, CMD_F, 20);
    chk(n >= T && n <= T+3 && flt === 1'b0, "confirm accel");
    wait_sig(4, CMD_F, 60);
    go(1'b0, 2'h0);
    wait_sig(0, 16'h0, 60);
    wait_sig(5, 16'h0, 10);
    wait_sig(2, 16'h0, 20);
    chk(n >= T && n <= T+3 && flt === 1'b0, "stop after drop");
    wait_sig(3, 16'h0, 80);
    go(1'b1, 2'h1);
    wait_sig(0, 16'h1, 60);
    wait_sig(1, 16'h1, 4*T+4);
    chk(n >= 4*T-1 && n <= 4*T+3, "confirm on timeout");
    clear_fault;
    $display("test confirm done");
  endtask

  task automatic t_confirm_faults;
    cfg(2'h3);
    go(1'b1, 2'h0);
    wait_sig(4, CMD_F, 120);
    go(1'b0, 2'h3);
    wait_sig(0, 16'h0, 60);
    wait_sig(1, 16'h1, 4*T+4);
    chk(n >= 4*T-1 && n <= 4*T+3, "confirm off timeout");
    clear_fault;
    cfg(2'h3);
    go(1'b1, 2'h0);
    wait_sig(4, CMD_F, 120);
    go(1'b0, 2'h1);
    wait_sig(1, 16'h1, 8);
    chk(out_freq > REL_F, "late trip on confirm drop");
    clear_fault;
    $display("test confirm faults done");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #400_000;
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize;
  end

  initial begin
    rstn_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    run_cmd = 1'b0;
    cur = 5'h0a;
    mode = 2'h0;
    out_freq = 16'h0;
    mismatches = 0;
    num_checks = 0;
    repeat (10) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    t_regs;
    t_disabled;
    t_plain;
    t_early_stop;
    t_low_current;
    t_confirm;
    t_confirm_faults;
    summarize;
  end
endmodule
